/* rtl/status_pkg.sv */
package status_pkg;

   // Widths of the status byte, the lower registers and the answer word.
   localparam int STAT_W = 8;
   localparam int SCPI_W = 16;
   localparam int DATA_W = 16;

   // Bit positions inside the status byte.
   localparam int BIT_ERRQ   = 2;
   localparam int BIT_QUEST  = 3;
   localparam int BIT_MSG    = 4;
   localparam int BIT_EVT    = 5;
   localparam int BIT_MASTER = 6;
   localparam int BIT_OPER   = 7;

   // Reset values of the writable and event parts and of the answer word.
   localparam logic [STAT_W-1:0] SVC_MASK_RESET   = 8'h00;
   localparam logic [STAT_W-1:0] STD_ENABLE_RESET = 8'h00;
   localparam logic [STAT_W-1:0] STD_EVENT_RESET  = 8'h00;
   localparam logic [SCPI_W-1:0] SCPI_PART_RESET  = 16'h0000;
   localparam logic [DATA_W-1:0] RSP_RESET        = 16'h0000;

   // Commands taken from the command parser.
   typedef enum logic [3:0] {
      OP_STATUS_QUERY,
      OP_SERIAL_POLL,
      OP_SVC_MASK_WRITE,
      OP_SVC_MASK_QUERY,
      OP_STD_ENABLE_WRITE,
      OP_STD_ENABLE_QUERY,
      OP_STD_EVENT_READ,
      OP_OPER_ENABLE_WRITE,
      OP_OPER_ENABLE_QUERY,
      OP_OPER_EVENT_READ,
      OP_QUEST_ENABLE_WRITE,
      OP_QUEST_ENABLE_QUERY,
      OP_QUEST_EVENT_READ
   } cmd_op_t;

   // One command with its write data.
   typedef struct packed {
      logic              valid;
      cmd_op_t           op;
      logic [DATA_W-1:0] wdata;
   } cmd_t;

   // One answer word.
   typedef struct packed {
      logic              valid;
      logic [DATA_W-1:0] rdata;
   } rsp_t;

endpackage : status_pkg

/* rtl/status_byte_service_request.sv */
`timescale 1ns/1ps
// Summary of operation
// - Bit 6 summarises all other status bits ANDed with their enables.
// - Status query and serial poll both return the current status byte.
// - Each status bit pairs with same mask bit; mask bit 6 ignored.
// - Enabled status bit rising 0 to 1 raises a service request.
// - Service mask is written by command and read back by query.
// - Bit 2 is set while the error queue holds an entry.
// - With mask bit 2 set, every new error entry requests service.
// - Bit 3 set when any enabled questionable event bit is set.
// - Bit 4 set while the output buffer holds a readable message.
// - Bit 5 set when any enabled standard event bit is set.
// - Bit 6 set while requesting service from any enabled other bit.
// - Bit 7 set when any enabled operation event bit is set.
// - Lower register summary is OR of event bits ANDed with enables.
// - Reading a lower register's event part clears it.
module status_byte_service_request
   import status_pkg::*;
#(
   parameter int OPER_W  = status_pkg::SCPI_W,
   parameter int QUEST_W = status_pkg::SCPI_W
)
(
   // Clock and reset.
   input  wire logic                          i_clk,
   input  wire logic                          i_rst,
   // Commands from the parser and their answers.
   input  wire status_pkg::cmd_t              i_cmd,
   output status_pkg::rsp_t                   o_rsp,
   // Filtered event sources, one-cycle pulses per bit.
   input  wire logic [status_pkg::STAT_W-1:0] i_std_event_set,
   input  wire logic [OPER_W-1:0]             i_oper_event_set,
   input  wire logic [QUEST_W-1:0]            i_quest_event_set,
   // Error queue and output buffer state.
   input  wire logic                          i_err_push,
   input  wire logic                          i_errq_not_empty,
   input  wire logic                          i_msg_avail,
   // Status byte and service request towards the controller.
   output logic [status_pkg::STAT_W-1:0]      o_status_byte,
   output logic                               o_srq
);

   import status_pkg::*;

   // The msb of the operation and questionable registers is held at zero, so each needs two bits.
   if (OPER_W < 2 || OPER_W > DATA_W || QUEST_W < 2 || QUEST_W > DATA_W)
   begin : g_bad_width
      $error("Lower register width must lie between 2 and DATA_W.");
   end

   // Stored parts.
   logic [STAT_W-1:0]  svc_mask;
   logic [STAT_W-1:0]  std_enable;
   logic [STAT_W-1:0]  std_event;
   logic [OPER_W-1:0]  oper_enable;
   logic [OPER_W-1:0]  oper_event;
   logic [QUEST_W-1:0] quest_enable;
   logic [QUEST_W-1:0] quest_event;
   logic [STAT_W-1:0]  status_prev;

   // Next values.
   logic [STAT_W-1:0]  next_svc_mask;
   logic [STAT_W-1:0]  next_std_enable;
   logic [STAT_W-1:0]  next_std_event;
   logic [OPER_W-1:0]  next_oper_enable;
   logic [OPER_W-1:0]  next_oper_event;
   logic [QUEST_W-1:0] next_quest_enable;
   logic [QUEST_W-1:0] next_quest_event;
   logic               next_srq;
   rsp_t               next_rsp;

   // Command decode.
   wire logic cmd_v          = i_cmd.valid;
   wire logic do_status_rd   = cmd_v && (i_cmd.op == OP_STATUS_QUERY ||
                                         i_cmd.op == OP_SERIAL_POLL);
   wire logic do_mask_wr     = cmd_v && i_cmd.op == OP_SVC_MASK_WRITE;
   wire logic do_mask_rd     = cmd_v && i_cmd.op == OP_SVC_MASK_QUERY;
   wire logic do_std_en_wr   = cmd_v && i_cmd.op == OP_STD_ENABLE_WRITE;
   wire logic do_std_en_rd   = cmd_v && i_cmd.op == OP_STD_ENABLE_QUERY;
   wire logic do_std_ev_rd   = cmd_v && i_cmd.op == OP_STD_EVENT_READ;
   wire logic do_oper_en_wr  = cmd_v && i_cmd.op == OP_OPER_ENABLE_WRITE;
   wire logic do_oper_en_rd  = cmd_v && i_cmd.op == OP_OPER_ENABLE_QUERY;
   wire logic do_oper_ev_rd  = cmd_v && i_cmd.op == OP_OPER_EVENT_READ;
   wire logic do_quest_en_wr = cmd_v && i_cmd.op == OP_QUEST_ENABLE_WRITE;
   wire logic do_quest_en_rd = cmd_v && i_cmd.op == OP_QUEST_ENABLE_QUERY;
   wire logic do_quest_ev_rd = cmd_v && i_cmd.op == OP_QUEST_EVENT_READ;

   // The top bit of each operation and questionable part always reads zero.
   wire logic [OPER_W-1:0] oper_keep =
      {1'b0, {(OPER_W-1){1'b1}}};
   wire logic [QUEST_W-1:0] quest_keep =
      {1'b0, {(QUEST_W-1){1'b1}}};

   // Lower register summaries, each an OR over ANDed pairs.
   wire logic std_sum   = |(std_event & std_enable);
   wire logic oper_sum  = |(oper_event & oper_enable);
   wire logic quest_sum = |(quest_event & quest_enable);

   // Status byte without its master bit; bits 0 and 1 are tied low.
   wire logic [STAT_W-1:0] status_low = {
      oper_sum,
      1'b0,
      std_sum,
      i_msg_avail,
      quest_sum,
      i_errq_not_empty,
      2'b00
   };

   // Mask bit 6 plays no part: status_low holds zero at bit 6.
   wire logic [STAT_W-1:0] status_enabled =
      status_low & svc_mask;

   // Master summary: requesting service while any enabled bit is set.
   wire logic master = |status_enabled;

   // Complete status byte as answered to query and serial poll.
   wire logic [STAT_W-1:0] status_byte =
      status_low | (STAT_W'(master) << BIT_MASTER);

   // Fresh rising edges on enabled bits; a mask change alone is no edge.
   wire logic [STAT_W-1:0] status_rise =
      status_low & ~status_prev & svc_mask;

   // A push with bit 2 enabled requests service even if the bit was set.
   wire logic err_request =
      i_err_push & svc_mask[BIT_ERRQ];

   // Event parts: a set arriving with a clearing read wins over the clear.
   always_comb
   begin
      next_std_event   = (std_event & ~{STAT_W{do_std_ev_rd}})
                         | i_std_event_set;
      next_oper_event  = ((oper_event & ~{OPER_W{do_oper_ev_rd}})
                         | i_oper_event_set) & oper_keep;
      next_quest_event = ((quest_event & ~{QUEST_W{do_quest_ev_rd}})
                         | i_quest_event_set) & quest_keep;
   end

   // Writable parts take the command data, trimmed to their width.
   always_comb
   begin
      next_svc_mask     = svc_mask;
      next_std_enable   = std_enable;
      next_oper_enable  = oper_enable;
      next_quest_enable = quest_enable;
      if (do_mask_wr)
      begin
         next_svc_mask = i_cmd.wdata[STAT_W-1:0];
      end
      if (do_std_en_wr)
      begin
         next_std_enable = i_cmd.wdata[STAT_W-1:0];
      end
      if (do_oper_en_wr)
      begin
         next_oper_enable = i_cmd.wdata[OPER_W-1:0] & oper_keep;
      end
      if (do_quest_en_wr)
      begin
         next_quest_enable = i_cmd.wdata[QUEST_W-1:0] & quest_keep;
      end
   end

   // Service request pulse for either kind of cause.
   always_comb
   begin
      next_srq = (|status_rise) | err_request;
   end

   // Answer mux; an event read returns the part before it is cleared.
   always_comb
   begin
      next_rsp       = '0;
      next_rsp.valid = do_status_rd | do_mask_rd | do_std_en_rd
                       | do_std_ev_rd | do_oper_en_rd | do_oper_ev_rd
                       | do_quest_en_rd | do_quest_ev_rd;
      if (do_status_rd)
      begin
         next_rsp.rdata = DATA_W'(status_byte);
      end
      else if (do_mask_rd)
      begin
         next_rsp.rdata = DATA_W'(svc_mask);
      end
      else if (do_std_en_rd)
      begin
         next_rsp.rdata = DATA_W'(std_enable);
      end
      else if (do_std_ev_rd)
      begin
         next_rsp.rdata = DATA_W'(std_event);
      end
      else if (do_oper_en_rd)
      begin
         next_rsp.rdata = DATA_W'(oper_enable);
      end
      else if (do_oper_ev_rd)
      begin
         next_rsp.rdata = DATA_W'(oper_event);
      end
      else if (do_quest_en_rd)
      begin
         next_rsp.rdata = DATA_W'(quest_enable);
      end
      else if (do_quest_ev_rd)
      begin
         next_rsp.rdata = DATA_W'(quest_event);
      end
   end

   // Mask and enable parts.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         svc_mask     <= SVC_MASK_RESET;
         std_enable   <= STD_ENABLE_RESET;
         oper_enable  <= OPER_W'(SCPI_PART_RESET);
         quest_enable <= QUEST_W'(SCPI_PART_RESET);
      end
      else
      begin
         svc_mask     <= next_svc_mask;
         std_enable   <= next_std_enable;
         oper_enable  <= next_oper_enable;
         quest_enable <= next_quest_enable;
      end
   end

   // Event parts.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         std_event   <= STD_EVENT_RESET;
         oper_event  <= OPER_W'(SCPI_PART_RESET);
         quest_event <= QUEST_W'(SCPI_PART_RESET);
      end
      else
      begin
         std_event   <= next_std_event;
         oper_event  <= next_oper_event;
         quest_event <= next_quest_event;
      end
   end

   // Edge memory, request pulse and registered outputs.
   // Reset leaves the edge memory and the mask at zero, so a bit already high when
   // reset ends raises no request on the first edge.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         status_prev   <= '0;
         o_srq         <= 1'b0;
         o_status_byte <= '0;
         o_rsp         <= '0;
      end
      else
      begin
         status_prev   <= status_low;
         o_srq         <= next_srq;
         o_status_byte <= status_byte;
         o_rsp         <= next_rsp;
      end
   end

endmodule : status_byte_service_request

/* tb/status_sva.sv */
`timescale 1ns/1ps
module status_sva
   import status_pkg::*;
#(
   parameter int OPER_W  = 16,
   parameter int QUEST_W = 16
)
(
   // Clock and reset.
   input wire logic                 i_clk,
   input wire logic                 i_rst,
   // Command port.
   input wire status_pkg::cmd_t     i_cmd,
   input wire status_pkg::rsp_t     o_rsp,
   // Sources.
   input wire logic [7:0]           i_std_event_set,
   input wire logic [OPER_W-1:0]    i_oper_event_set,
   input wire logic [QUEST_W-1:0]   i_quest_event_set,
   input wire logic                 i_err_push,
   input wire logic                 i_errq_not_empty,
   input wire logic                 i_msg_avail,
   // Status outputs.
   input wire logic [7:0]           o_status_byte,
   input wire logic                 o_srq
);
   // Mirror of the service mask, so requests can be tied to it.
   logic [7:0] mask;

   // Command decode; writes never answer, codes above 12 are ignored.
   wire logic is_stb = i_cmd.valid
                       && i_cmd.op inside {OP_STATUS_QUERY, OP_SERIAL_POLL};
   wire logic is_mq  = i_cmd.valid && i_cmd.op == OP_SVC_MASK_QUERY;
   wire logic is_wr  = i_cmd.op inside {OP_SVC_MASK_WRITE,
                                        OP_STD_ENABLE_WRITE,
                                        OP_OPER_ENABLE_WRITE,
                                        OP_QUEST_ENABLE_WRITE};
   wire logic is_q   = i_cmd.valid && !is_wr
                       && i_cmd.op <= OP_QUEST_EVENT_READ;

   // The mirror follows mask writes only, like the mask itself.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mask <= 8'h00;
      end
      else if (i_cmd.valid && i_cmd.op == OP_SVC_MASK_WRITE)
      begin
         mask <= i_cmd.wdata[7:0];
      end
   end

   // All checks use the rising edge and rest while reset is high.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // The unused bits never show up.
   property p_unused;
      o_status_byte[1:0] == 2'b00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("Unused status bits are set.");

   // Level bits follow their sources one edge later.
   property p_errq;
      !$past(i_rst) |-> o_status_byte[2] == $past(i_errq_not_empty);
   endproperty
   a_errq: assert property (p_errq)
      else $error("Status bit 2 does not follow the error queue.");

   property p_msg;
      !$past(i_rst) |-> o_status_byte[4] == $past(i_msg_avail);
   endproperty
   a_msg: assert property (p_msg)
      else $error("Status bit 4 does not follow the output buffer.");

   // The mask must be steady so that the one-edge lag lines up.
   property p_master;
      !$past(i_rst) && $stable(mask)
      |-> o_status_byte[6] == |(o_status_byte & mask & 8'hbf);
   endproperty
   a_master: assert property (p_master)
      else $error("Master summary bit is wrong.");

   property p_srq_err;
      i_err_push && mask[2] |=> o_srq;
   endproperty
   a_srq_err: assert property (p_srq_err)
      else $error("Error queue entry gave no service request.");

   property p_srq_rise;
      !$past(i_rst)
      && |(o_status_byte & ~$past(o_status_byte) & $past(mask) & 8'hbf)
      |-> o_srq;
   endproperty
   a_srq_rise: assert property (p_srq_rise)
      else $error("Enabled rising status bit gave no request.");

   // Every request has a cause, and mask bit 6 never counts.
   property p_srq_cause;
      o_srq |-> $past(i_err_push && mask[2])
                || |(o_status_byte & ~$past(o_status_byte) & $past(mask)
                     & 8'hbf);
   endproperty
   a_srq_cause: assert property (p_srq_cause)
      else $error("Service request without a cause.");

   // Answers come one edge after the command, and never for writes.
   property p_rsp;
      !$past(i_rst) |-> o_rsp.valid == $past(is_q);
   endproperty
   a_rsp: assert property (p_rsp)
      else $error("Answer strobe has the wrong timing.");

   property p_stb;
      $past(is_stb) |-> o_rsp.rdata == {8'h00, o_status_byte};
   endproperty
   a_stb: assert property (p_stb)
      else $error("Status answer differs from the status byte.");

   property p_mask;
      $past(is_mq) |-> o_rsp.rdata == {8'h00, $past(mask)};
   endproperty
   a_mask: assert property (p_mask)
      else $error("Mask answer differs from the written mask.");
endmodule : status_sva

bind status_byte_service_request status_sva
#(
   .OPER_W  (OPER_W),
   .QUEST_W (QUEST_W)
)
u_sva
(
   .i_clk             (i_clk),
   .i_rst             (i_rst),
   .i_cmd             (i_cmd),
   .o_rsp             (o_rsp),
   .i_std_event_set   (i_std_event_set),
   .i_oper_event_set  (i_oper_event_set),
   .i_quest_event_set (i_quest_event_set),
   .i_err_push        (i_err_push),
   .i_errq_not_empty  (i_errq_not_empty),
   .i_msg_avail       (i_msg_avail),
   .o_status_byte     (o_status_byte),
   .o_srq             (o_srq)
);

/* tb/ctrl_model.sv */
`timescale 1ns/1ps
module ctrl_model
   import status_pkg::*;
(
   // Clock.
   input  wire logic              i_clk,
   // Command towards the device and its answer.
   output status_pkg::cmd_t       o_cmd,
   input  wire status_pkg::rsp_t  i_rsp
);
   // Idle until the bench asks for a transfer.
   initial o_cmd = '0;

   // One command for one cycle; the answer stands one cycle only, so it is
   // taken in that cycle. Released data is inverted so stale values fail.
   task xfer(input cmd_op_t op, input logic [15:0] wd,
             output logic [15:0] rd, output logic got);
      @(negedge i_clk);
      o_cmd = {1'b1, op, wd};
      @(negedge i_clk);
      got = i_rsp.valid; // Query and serial poll share this path.
      rd = got ? i_rsp.rdata : 16'hxxxx;
      o_cmd = {1'b0, op, ~wd};
   endtask : xfer
endmodule : ctrl_model

/* tb/status_byte_service_request_tb.sv */
`timescale 1ns/1ps
module status_byte_service_request_tb;
   import status_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   cmd_t        cmd;
   rsp_t        rsp;
   logic [7:0]  std_set = 8'h00;
   logic [15:0] oper_set = 16'h0000;
   logic [15:0] quest_set = 16'h0000;
   logic        err_push = 1'b0;
   logic        errq = 1'b0;
   logic        msg = 1'b0;
   logic [7:0]  stb;
   logic        srq;
   logic [15:0] rd;
   logic        got;
   logic [15:0] srq_n = 16'h0000;
   int          mismatches = 0;
   int          checks_done = 0;

   // 250 MHz clock.
   always #2 clk = ~clk;

   // Count request pulses; every cycle with a cause must give exactly one.
   // Pulses are counted mid-cycle, where the registered pulse has settled.
   always @(negedge clk)
   begin
      if (srq === 1'b1)
      begin
         srq_n <= srq_n + 16'h0001;
      end
   end

   status_byte_service_request uut (.i_clk(clk), .i_rst(rst), .i_cmd(cmd),
      .o_rsp(rsp), .i_std_event_set(std_set), .i_oper_event_set(oper_set),
      .i_quest_event_set(quest_set), .i_err_push(err_push),
      .i_errq_not_empty(errq), .i_msg_avail(msg), .o_status_byte(stb),
      .o_srq(srq));
   ctrl_model host (.i_clk(clk), .o_cmd(cmd), .i_rsp(rsp));

   task chk(string name, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task q(cmd_op_t op, logic [15:0] exp);
      host.xfer(op, 16'h0000, rd, got);
      chk(op.name(), rd, exp);
   endtask : q

   task w(cmd_op_t op, logic [15:0] d);
      host.xfer(op, d, rd, got);
   endtask : w

   // One-cycle event pulses into the lower registers.
   task ev(logic [7:0] s, logic [15:0] o, logic [15:0] qs);
      @(negedge clk);
      std_set = s;
      oper_set = o;
      quest_set = qs;
      @(negedge clk);
      std_set = 8'h00;
      oper_set = 16'h0000;
      quest_set = 16'h0000;
   endtask : ev

   task final_report();
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // Watchdog, far beyond the some 70 cycles the sequence needs.
   initial
   begin
      #20000;
      mismatches++;
      final_report();
   end

   // Main sequence; each step but the last, which leaves msg high, leaves every source idle again.
   initial
   begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      q(OP_SVC_MASK_QUERY, 16'h0000);
      q(OP_STATUS_QUERY, 16'h0000);
      w(OP_SVC_MASK_WRITE, 16'h00bc);
      q(OP_SVC_MASK_QUERY, 16'h00bc);
      @(negedge clk);
      errq = 1'b1;
      err_push = 1'b1;
      @(negedge clk);
      @(negedge clk);
      err_push = 1'b0;
      q(OP_SERIAL_POLL, 16'h0044);
      chk("status_byte", {8'h00, stb}, 16'h0044);
      chk("srq_errors", srq_n, 16'h0002);
      errq = 1'b0;
      msg = 1'b1;
      q(OP_STATUS_QUERY, 16'h0050);
      q(OP_SERIAL_POLL, 16'h0050);
      msg = 1'b0;
      w(OP_STD_ENABLE_WRITE, 16'h0001);
      ev(8'h01, 16'h0000, 16'h0000);
      q(OP_STATUS_QUERY, 16'h0060);
      q(OP_STD_ENABLE_QUERY, 16'h0001);
      q(OP_STD_EVENT_READ, 16'h0001);
      q(OP_STD_EVENT_READ, 16'h0000);
      // A set pulse in the cycle of a clearing read must survive it.
      fork
         ev(8'h02, 16'h0000, 16'h0000);
         q(OP_STD_EVENT_READ, 16'h0000);
      join
      q(OP_STD_EVENT_READ, 16'h0002);
      // Bit 15 of the operation parts is offered and must read back as zero.
      w(OP_OPER_ENABLE_WRITE, 16'h8001);
      w(OP_QUEST_ENABLE_WRITE, 16'h0004);
      ev(8'h00, 16'h8001, 16'h0001);
      q(OP_STATUS_QUERY, 16'h00c0);
      q(OP_OPER_ENABLE_QUERY, 16'h0001);
      q(OP_OPER_EVENT_READ, 16'h0001);
      ev(8'h00, 16'h0000, 16'h0004);
      q(OP_STATUS_QUERY, 16'h0048);
      q(OP_QUEST_ENABLE_QUERY, 16'h0004);
      q(OP_QUEST_EVENT_READ, 16'h0005);
      q(OP_STATUS_QUERY, 16'h0000);
      chk("srq_rises", srq_n, 16'h0006);
      w(OP_SVC_MASK_WRITE, 16'h0040);
      msg = 1'b1;
      q(OP_STATUS_QUERY, 16'h0010);
      chk("status_byte", {8'h00, stb}, 16'h0010);
      w(OP_SVC_MASK_WRITE, 16'h0010);
      q(OP_STATUS_QUERY, 16'h0050);
      chk("status_byte", {8'h00, stb}, 16'h0050);
      chk("srq_late_mask", srq_n, 16'h0006);
      host.xfer(cmd_op_t'(4'hd), 16'h0000, rd, got);
      chk("reserved_op", {15'h0000, got}, 16'h0000);
      final_report();
   end
endmodule : status_byte_service_request_tb
